// ---- src/dbg_id_baud_params.svh ----
// register offsets, field positions, reset values, baud prescale and a memory type code
`ifndef DBG_ID_BAUD_PARAMS_SVH
`define DBG_ID_BAUD_PARAMS_SVH

`define OFS_BAUD_DIVISOR        32'hfffff220
`define OFS_CHIP_IDENTITY       32'hfffff240
`define OFS_CHIP_IDENTITY_EXT   32'hfffff244
`define OFS_TEST_RESET_FORCE    32'hfffff248

`define DIV_LSB                 0
`define DIV_W                   16
`define DIV_RESET               16'h0000
`define HOLD_BIT                0
`define HOLD_RESET              1'b0
`define BAUD_PRESCALE           16

`define ID_REV_LSB              0
`define ID_CORE_LSB             5
`define ID_PSIZE_LSB            8
`define ID_PSIZE2_LSB           12
`define ID_RAM_LSB              16
`define ID_FAMILY_LSB           20
`define ID_PTYPE_LSB            28
`define ID_MORE_BIT             31

`define MEMTYPE_ROM_FLASH       3'h3

`endif

// ---- src/dbg_id_baud_pkg.sv ----
// types for the identity and baud register bank
package dbg_id_baud_pkg;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic        more_id_flag;
      logic [2:0]  program_memory_type;
      logic [7:0]  family_id;
      logic [3:0]  onchip_ram_size_code;
      logic [3:0]  second_program_memory_size;
      logic [3:0]  program_memory_size;
      logic [2:0]  core_type_code;
      logic [4:0]  revision;
   } chip_identity_t;
endpackage

// ---- src/dbg_id_baud_regs.sv ----
// identity, baud divisor and tap reset hold registers
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "dbg_id_baud_params.svh"

module dbg_id_baud_regs
   import dbg_id_baud_pkg::*;
#(
   parameter logic [4:0]  REVISION    = 5'h01, // arbitrary value
   parameter logic [2:0]  CORE_TYPE   = 3'h1,  // arbitrary value
   parameter logic [3:0]  PSIZE       = 4'h7,
   parameter logic [3:0]  PSIZE2      = 4'h0,
   parameter logic [3:0]  RAM_SIZE    = 4'h9,
   parameter logic [7:0]  FAMILY      = 8'ha5, // arbitrary value
   parameter logic [2:0]  PTYPE       = 3'h2,
   parameter logic        MORE_ID     = 1'b0,
   parameter logic [31:0] EXTRA_ID    = 32'h0000_0000 // arbitrary value
) (
   // clock and power-on reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // register port
   input  wire logic [31:0] ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output      logic [31:0] RDATA,
   // baud clock enable, one cycle per baud tick
   output      logic        BAUD_TICK,
   // processor tap reset, active low
   output      logic        TAP_RST_N
);

   // refused at elaboration: an extension word needs the extension flag
   if (MORE_ID == 1'b0 && EXTRA_ID != 32'h0) begin : g_ext_chk
      $error("extension word must be zero without extension flag");
   end

   reg_req_t       req;
   chip_identity_t id;
   logic [15:0]    div_r, div_nxt;
   logic           hold_r, hold_nxt;
   logic [31:0]    rdata_r, rdata_nxt;
   logic [3:0]     pre_r, pre_nxt;
   logic [15:0]    cnt_r, cnt_nxt;
   logic           tick_r, tick_nxt;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // fixed identity fields, no storage so software cannot alter them
   always_comb begin
      id.revision                   = REVISION;
      id.core_type_code             = CORE_TYPE;
      id.program_memory_size        = PSIZE;
      id.second_program_memory_size = PSIZE2;
      id.onchip_ram_size_code       = RAM_SIZE;
      id.family_id                  = FAMILY;
      id.program_memory_type        = PTYPE;
      id.more_id_flag               = MORE_ID;
   end

   // register writes and read mux
   always_comb begin
      div_nxt   = div_r;
      hold_nxt  = hold_r;
      rdata_nxt = 32'h0000_0000;
      if (req.wr) begin
         unique case (req.addr)
            `OFS_BAUD_DIVISOR:
               div_nxt = req.wdata[`DIV_LSB +: `DIV_W];
            `OFS_TEST_RESET_FORCE:
               hold_nxt = req.wdata[`HOLD_BIT];
            default: ;
         endcase
      end
      if (req.rd) begin
         unique case (req.addr)
            `OFS_BAUD_DIVISOR:
               rdata_nxt = {16'h0000, div_r};
            `OFS_CHIP_IDENTITY:
               rdata_nxt = id;
            `OFS_CHIP_IDENTITY_EXT:
               rdata_nxt = MORE_ID ? EXTRA_ID : 32'h0;
            `OFS_TEST_RESET_FORCE:
               rdata_nxt = {31'h0, hold_r};
            default:
               rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_r   <= `DIV_RESET;
         hold_r  <= `HOLD_RESET;
         rdata_r <= 32'h0000_0000;
      end else begin
         div_r   <= div_nxt;
         hold_r  <= hold_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // baud generator: above divisor one, prescale by 16 then count divisor; a new divisor
   // restarts the count so a slower setting never waits a stale period
   always_comb begin
      pre_nxt  = pre_r;
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      // restart checked first so leaving divisor one never keeps stale counts
      if (div_nxt != div_r || div_r == 16'h0000) begin
         pre_nxt = 4'h0;
         cnt_nxt = 16'h0000;
      end else if (div_r == 16'h0001) begin
         tick_nxt = 1'b1;
      end else begin
         pre_nxt = pre_r + 4'h1;
         if (pre_r == 4'(`BAUD_PRESCALE - 1)) begin
            if (cnt_r >= div_r - 16'h0001) begin
               cnt_nxt  = 16'h0000;
               tick_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pre_r  <= 4'h0;
         cnt_r  <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         pre_r  <= pre_nxt;
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign RDATA     = rdata_r;
   assign BAUD_TICK = tick_r;
   // reset is combined with the hold so power-on reset passes at once
   assign TAP_RST_N = RST_N & ~hold_r;

endmodule // dbg_id_baud_regs

// ---- verification/dbg_id_baud_regs_bench.sv ----
// self-checking bench for the identity and baud register bank
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module dbg_id_baud_regs_bench;
   import dbg_id_baud_pkg::*;
   logic           CLK, RST_N, WR, RD, BAUD_TICK, TAP_RST_N;
   logic [31:0]    ADDR, WDATA, RDATA;
   int             errors, n_checks, n;
   chip_identity_t id_e = '{1'b0, 3'h2, 8'ha5, 4'h9, 4'h0, 4'h7, 3'h1, 5'h01};
   dbg_id_baud_regs dut_u (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .BAUD_TICK(BAUD_TICK), .TAP_RST_N(TAP_RST_N));
   // one idle cycle after each strobe keeps a strobe from being driven twice
   task wr(input logic [31:0] a, input logic [31:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      @(posedge CLK);
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      // read data stand only until the next edge, so look mid-cycle
      @(negedge CLK);
      `CHK(RDATA, e)
      @(posedge CLK);
   endtask
   task results;
      if (errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   initial begin
      #50000;
      errors++;
      results();
   end
   initial begin
      {RST_N, WR, RD, ADDR, WDATA} = '0;
      repeat (8) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      `CHK(TAP_RST_N, 1'b1)
      rd(32'hfffff220, 32'h0);
      wr(32'hfffff220, 32'hffff0003);
      rd(32'hfffff220, 32'h3);
      wr(32'hfffff240, 32'h0);
      rd(32'hfffff240, id_e);
      rd(32'hfffff244, 32'h0);
      rd(32'hfffff224, 32'h0);
      wr(32'hfffff248, 32'hffffffff);
      `CHK(TAP_RST_N, 1'b0)
      rd(32'hfffff248, 32'h1);
      wr(32'hfffff248, 32'h0);
      `CHK(TAP_RST_N, 1'b1)
      // mid-run reset with the hold set: tap reset follows, hold clears
      wr(32'hfffff248, 32'h1);
      RST_N <= 1'b0;
      @(posedge CLK);
      `CHK(TAP_RST_N, 1'b0)
      RST_N <= 1'b1;
      @(posedge CLK);
      `CHK(TAP_RST_N, 1'b1)
      rd(32'hfffff220, 32'h0);
      wr(32'hfffff220, 32'h1);
      @(posedge CLK);
      repeat (5) begin @(posedge CLK); `CHK(BAUD_TICK, 1'b1) end
      wr(32'hfffff220, 32'h2);
      repeat (3) @(posedge CLK);
      while (BAUD_TICK !== 1'b1 && n < 99) begin @(posedge CLK); n++; end
      n = 0;
      do begin @(posedge CLK); n++; end while (BAUD_TICK !== 1'b1 && n < 99);
      `CHK(n, 32)
      wr(32'hfffff220, 32'h0);
      @(posedge CLK);
      repeat (40) begin @(posedge CLK); `CHK(BAUD_TICK, 1'b0) end
      results();
   end
endmodule // dbg_id_baud_regs_bench

// ---- verification/dbg_id_baud_regs_monitor.sv ----
// port assertions for the identity and baud register bank
`timescale 1ns/100ps
module dbg_id_baud_regs_monitor (
   // clock, reset, register port
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic [31:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   // watched outputs
   input wire logic [31:0] RDATA,
   input wire logic        BAUD_TICK,
   input wire logic        TAP_RST_N
);
   logic div_w;
   logic frc_w;
   assign div_w = WR && ADDR == 32'hfffff220;
   assign frc_w = WR && ADDR == 32'hfffff248;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   idle_zero_a: assert property (!RD |=> RDATA == 32'h0)
      else $error("read data not idle");
   hold_low_a: assert property (frc_w && WDATA[0] ##1 !frc_w
      |-> !TAP_RST_N [*2]) else $error("tap reset not held");
   hold_off_a: assert property (frc_w && !WDATA[0] |=> TAP_RST_N)
      else $error("tap reset still held");
   ext_zero_a: assert property (RD && ADDR == 32'hfffff244
      |=> !RDATA) else $error("extension word not zero");
   div_upper_a: assert property (RD && ADDR == 32'hfffff220
      |=> RDATA[31:16] == 16'h0) else $error("divisor upper bits set");
   unmapped_a: assert property (RD && ADDR == 32'hfffff224
      |=> !RDATA) else $error("unmapped read not zero");
   stop_tick_a: assert property (div_w && WDATA[15:0] == 16'h0
      |=> ##1 !BAUD_TICK [*8]) else $error("tick with divisor zero");
   fast_tick_a: assert property (div_w && WDATA[15:0] == 16'h1
      |=> ##1 BAUD_TICK [*6]) else $error("tick missing at divisor one");
endmodule // dbg_id_baud_regs_monitor
bind dbg_id_baud_regs dbg_id_baud_regs_monitor mon_u (.CLK(CLK),
   .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .BAUD_TICK(BAUD_TICK), .TAP_RST_N(TAP_RST_N));
